// file: hdl/smc_pkg.sv
package smc_pkg;
  localparam int unsigned CHANNELS = 4096;
  localparam int unsigned BANDS = 7;
  localparam int unsigned MASKS = 14;
  localparam int unsigned IN_W = 32;
  localparam int unsigned OUT_W = 12;
  localparam int unsigned IDX_W = 12;
  localparam int unsigned TOP_W = 5;
  localparam int unsigned BAND_W = 3;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned CNT_W = 8;
  localparam int unsigned WORD_W = BAND_W + TOP_W + OUT_W;
  localparam logic [IDX_W-1:0] LAST_CH = 12'hfff;
  // Band edges are an assumption, set here so they can move in one place
  localparam logic [IDX_W-1:0] BAND_START [BANDS] =
    '{12'h000, 12'h249, 12'h492, 12'h6db, 12'h924, 12'hb6d, 12'hdb6};
  localparam logic [TOP_W-1:0] TOP_MIN = 5'h0b;
  localparam logic [TOP_W-1:0] CAL_RESET = 5'h00;
  localparam logic [TOP_W-1:0] NOM_RESET = 5'h0b;
  localparam logic [MASKS-1:0][TOP_W-1:0] MASK_RESET = {{BANDS{NOM_RESET}}, {BANDS{CAL_RESET}}};
  localparam logic [7:0] VAL_MIN = 8'h0b;
  localparam logic [7:0] VAL_MAX = 8'h1f;
  // Telecommand byte layout
  localparam logic [4:0] HDR_BYTES = 5'h0a;
  localparam logic [4:0] DATA_FIRST = 5'h0a;
  localparam logic [4:0] DATA_LAST = 5'h17;
  localparam logic [4:0] TC_LAST_POS = 5'h19;
  localparam logic [7:0] HDR_EXP [10] =
    '{8'h1c, 8'h7c, 8'hc0, 8'h00, 8'h00, 8'h13, 8'h11, 8'hc0, 8'h12, 8'h00};
  localparam logic [7:0] HDR_MASK [10] =
    '{8'hff, 8'hff, 8'hf8, 8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
  // Register map
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h04;
  localparam logic [ADDR_W-1:0] MASK_BASE = 8'h10;
  localparam logic [ADDR_W-1:0] MASK_END = 8'h44;
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RESET = 1'b1;
  localparam int unsigned ST_MANUAL_BIT = 0;
  localparam int unsigned ST_DRAIN_BIT = 1;
  localparam int unsigned ST_ACC_LSB = 8;
  localparam int unsigned ST_REJ_LSB = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef enum logic {ST_FILL, ST_DRAIN} smc_state_t;
endpackage

// file: hdl/smc_fifo.sv
`timescale 1ns/1ps
module smc_fifo #(
  parameter int unsigned W = 20,
  parameter int unsigned DEPTH = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  import smc_pkg::*;
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
  logic [PW:0] cnt_ff, nxt_cnt;
  logic push, pop;

  assign in_ready = (cnt_ff != (PW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data = mem[rp_ff];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    nxt_wp = wp_ff;
    nxt_rp = rp_ff;
    nxt_cnt = cnt_ff;
    if (push)
    begin
      nxt_wp = (wp_ff == PW'(DEPTH-1)) ? '0 : wp_ff + 1'b1;
    end
    if (pop)
    begin
      nxt_rp = (rp_ff == PW'(DEPTH-1)) ? '0 : rp_ff + 1'b1;
    end
    if (push && !pop)
    begin
      nxt_cnt = cnt_ff + 1'b1;
    end
    else if (pop && !push)
    begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
  end

  // Storage needs no reset; count guards it
  always_ff @(posedge aclk)
  begin
    if (push)
    begin
      mem[wp_ff] <= in_data;
    end
  end
endmodule

// file: hdl/smc_tc_parser.sv
`timescale 1ns/1ps
module smc_tc_parser (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] tc_data,
  input wire logic tc_valid,
  input wire logic tc_last,
  output logic tc_ready,
  output logic cmd_accept,
  output logic cmd_reject,
  output logic [smc_pkg::MASKS-1:0][smc_pkg::TOP_W-1:0] cmd_masks
);
  import smc_pkg::*;
  logic [4:0] pos_ff, nxt_pos;
  logic bad_ff, nxt_bad;
  logic [7:0] hi_ff, nxt_hi;
  logic [15:0] sum_ff, nxt_sum;
  logic [MASKS-1:0][TOP_W-1:0] val_ff, nxt_val;
  logic acc_ff, nxt_acc, rej_ff, nxt_rej;
  logic [15:0] word;
  logic [4:0] slot;
  logic ok;

  // Parser never stalls the command path
  assign tc_ready = 1'b1;
  assign cmd_accept = acc_ff;
  assign cmd_reject = rej_ff;
  assign cmd_masks = val_ff;

  always_comb
  begin
    nxt_pos = pos_ff;
    nxt_bad = bad_ff;
    nxt_hi = hi_ff;
    nxt_sum = sum_ff;
    nxt_val = val_ff;
    nxt_acc = 1'b0;
    nxt_rej = 1'b0;
    word = {hi_ff, tc_data};
    slot = pos_ff - DATA_FIRST;
    ok = 1'b0;
    if (tc_valid)
    begin
      if (pos_ff < HDR_BYTES)
      begin
        if ((tc_data & HDR_MASK[pos_ff[3:0]]) != HDR_EXP[pos_ff[3:0]])
        begin
          nxt_bad = 1'b1;
        end
      end
      else if (pos_ff <= DATA_LAST)
      begin
        if (tc_data < VAL_MIN || tc_data > VAL_MAX)
        begin
          nxt_bad = 1'b1;
        end
        nxt_val[slot[3:0]] = tc_data[TOP_W-1:0];
      end
      if (!pos_ff[0])
      begin
        nxt_hi = tc_data;
      end
      else
      begin
        nxt_sum = sum_ff ^ word;
      end
      if (tc_last || pos_ff == TC_LAST_POS)
      begin
        // Words XOR to zero over the whole packet, checksum word included
        ok = !nxt_bad && tc_last && pos_ff == TC_LAST_POS && (sum_ff ^ word) == 16'h0000;
        nxt_acc = ok;
        nxt_rej = !ok;
        nxt_pos = '0;
        nxt_bad = 1'b0;
        nxt_sum = '0;
      end
      else
      begin
        nxt_pos = pos_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pos_ff <= '0;
      bad_ff <= 1'b0;
      hi_ff <= '0;
      sum_ff <= '0;
      val_ff <= MASK_RESET;
      acc_ff <= 1'b0;
      rej_ff <= 1'b0;
    end
    else
    begin
      pos_ff <= nxt_pos;
      bad_ff <= nxt_bad;
      hi_ff <= nxt_hi;
      sum_ff <= nxt_sum;
      val_ff <= nxt_val;
      acc_ff <= nxt_acc;
      rej_ff <= nxt_rej;
    end
  end
endmodule

// file: hdl/smc_compressor.sv
`timescale 1ns/1ps
module smc_compressor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [smc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [smc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] tc_data,
  input wire logic tc_valid,
  input wire logic tc_last,
  output logic tc_ready,
  input wire logic [smc_pkg::IN_W-1:0] spec_data,
  input wire logic spec_cal,
  input wire logic spec_valid,
  output logic spec_ready,
  output logic [smc_pkg::OUT_W-1:0] cmp_data,
  output logic [smc_pkg::BAND_W-1:0] cmp_band,
  output logic [smc_pkg::TOP_W-1:0] cmp_mult,
  output logic cmp_valid,
  input wire logic cmp_ready,
  output logic mode_manual
);
  import smc_pkg::*;

  function automatic logic [BAND_W-1:0] band_of(input logic [IDX_W-1:0] idx);
    logic [BAND_W-1:0] b;
    b = '0;
    for (int i = 1; i < BANDS; i++)
    begin
      if (idx >= BAND_START[i])
      begin
        b = BAND_W'(i);
      end
    end
    return b;
  endfunction

  function automatic logic [TOP_W-1:0] msb_of(input logic [IN_W-1:0] v);
    logic [TOP_W-1:0] m;
    m = '0;
    for (int i = 0; i < IN_W; i++)
    begin
      if (v[i])
      begin
        m = TOP_W'(i);
      end
    end
    return m;
  endfunction

  function automatic logic [TOP_W-1:0] shift_of(input logic [TOP_W-1:0] top);
    return (top > TOP_MIN) ? top - TOP_MIN : '0;
  endfunction

  function automatic logic addr_known(input logic [ADDR_W-1:0] a);
    return (a[1:0] == 2'b00) &&
      (a == CTRL_ADDR || a == STATUS_ADDR || (a >= MASK_BASE && a <= MASK_END));
  endfunction

  // Command path and mask store
  logic cmd_accept, cmd_reject;
  logic [MASKS-1:0][TOP_W-1:0] cmd_masks;
  logic [MASKS-1:0][TOP_W-1:0] masks_ff, nxt_masks;
  logic manual_ff, nxt_manual;
  logic [CNT_W-1:0] acc_cnt_ff, nxt_acc_cnt, rej_cnt_ff, nxt_rej_cnt;

  smc_tc_parser u_parser (
    .aclk(aclk),
    .aresetn(aresetn),
    .tc_data(tc_data),
    .tc_valid(tc_valid),
    .tc_last(tc_last),
    .tc_ready(tc_ready),
    .cmd_accept(cmd_accept),
    .cmd_reject(cmd_reject),
    .cmd_masks(cmd_masks)
  );

  always_comb
  begin
    nxt_masks = masks_ff;
    nxt_manual = manual_ff;
    nxt_acc_cnt = acc_cnt_ff;
    nxt_rej_cnt = rej_cnt_ff;
    if (cmd_accept)
    begin
      nxt_masks = cmd_masks;
      nxt_manual = 1'b1;
      nxt_acc_cnt = acc_cnt_ff + 1'b1;
    end
    if (cmd_reject)
    begin
      nxt_rej_cnt = rej_cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      masks_ff <= MASK_RESET;
      manual_ff <= 1'b0;
      acc_cnt_ff <= '0;
      rej_cnt_ff <= '0;
    end
    else
    begin
      masks_ff <= nxt_masks;
      manual_ff <= nxt_manual;
      acc_cnt_ff <= nxt_acc_cnt;
      rej_cnt_ff <= nxt_rej_cnt;
    end
  end

  assign mode_manual = manual_ff;

  // Spectrum capture and drain
  logic [IN_W-1:0] spec_mem [CHANNELS];
  smc_state_t st_ff, nxt_st;
  logic [IDX_W-1:0] wr_idx_ff, nxt_wr_idx, rd_idx_ff, nxt_rd_idx;
  logic [BANDS-1:0][IN_W-1:0] or_ff, nxt_or;
  logic [BANDS-1:0][TOP_W-1:0] sel_ff, nxt_sel, top_ff, nxt_top;
  logic snap_man_ff, nxt_snap_man, rd_done_ff, nxt_rd_done, pend_ff, nxt_pend;
  logic en_ff, nxt_en;
  logic [IN_W-1:0] rd_data_ff;
  logic [BAND_W-1:0] rd_band_ff;
  logic take, issue, buf_ready;
  logic [BAND_W-1:0] wr_band;
  logic [TOP_W-1:0] cur_shift;
  logic [WORD_W-1:0] buf_in, buf_out;

  assign spec_ready = (st_ff == ST_FILL) && en_ff;
  assign take = spec_valid && spec_ready;
  assign wr_band = band_of(wr_idx_ff);
  // One read in flight; the buffer absorbs a stall without losing it
  assign issue = (st_ff == ST_DRAIN) && !rd_done_ff && (!pend_ff || buf_ready);

  always_comb
  begin
    nxt_st = st_ff;
    nxt_wr_idx = wr_idx_ff;
    nxt_rd_idx = rd_idx_ff;
    nxt_or = or_ff;
    nxt_sel = sel_ff;
    nxt_top = top_ff;
    nxt_snap_man = snap_man_ff;
    nxt_rd_done = rd_done_ff;
    nxt_pend = pend_ff && !buf_ready;
    case (st_ff)
      ST_FILL:
      begin
        if (take)
        begin
          if (wr_idx_ff == '0)
          begin
            nxt_or = '0;
            nxt_snap_man = manual_ff;
            nxt_sel = spec_cal ? masks_ff[BANDS-1:0] : masks_ff[MASKS-1:BANDS];
          end
          nxt_or[wr_band] = nxt_or[wr_band] | spec_data;
          nxt_wr_idx = wr_idx_ff + 1'b1;
          if (wr_idx_ff == LAST_CH)
          begin
            for (int b = 0; b < BANDS; b++)
            begin
              // Top set bit of the band OR equals that of its largest channel
              nxt_top[b] = nxt_snap_man ? nxt_sel[b] : msb_of(nxt_or[b]);
            end
            nxt_rd_idx = '0;
            nxt_rd_done = 1'b0;
            nxt_st = ST_DRAIN;
          end
        end
      end
      ST_DRAIN:
      begin
        if (issue)
        begin
          nxt_pend = 1'b1;
          nxt_rd_idx = rd_idx_ff + 1'b1;
          nxt_rd_done = (rd_idx_ff == LAST_CH);
        end
        if (rd_done_ff && !pend_ff)
        begin
          nxt_st = ST_FILL;
        end
      end
      default:
      begin
        nxt_st = ST_FILL;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_ff <= ST_FILL;
      wr_idx_ff <= '0;
      rd_idx_ff <= '0;
      or_ff <= '0;
      sel_ff <= '0;
      top_ff <= '0;
      snap_man_ff <= 1'b0;
      rd_done_ff <= 1'b0;
      pend_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      wr_idx_ff <= nxt_wr_idx;
      rd_idx_ff <= nxt_rd_idx;
      or_ff <= nxt_or;
      sel_ff <= nxt_sel;
      top_ff <= nxt_top;
      snap_man_ff <= nxt_snap_man;
      rd_done_ff <= nxt_rd_done;
      pend_ff <= nxt_pend;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (take)
    begin
      spec_mem[wr_idx_ff] <= spec_data;
    end
    if (issue)
    begin
      rd_data_ff <= spec_mem[rd_idx_ff];
      rd_band_ff <= band_of(rd_idx_ff);
    end
  end

  assign cur_shift = shift_of(top_ff[rd_band_ff]);
  assign buf_in = {rd_band_ff, snap_man_ff ? TOP_W'(0) : cur_shift,
    OUT_W'(rd_data_ff >> cur_shift)};

  smc_fifo #(.W(WORD_W), .DEPTH(2)) u_buf (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_data(buf_in),
    .in_valid(pend_ff),
    .in_ready(buf_ready),
    .out_data(buf_out),
    .out_valid(cmp_valid),
    .out_ready(cmp_ready)
  );

  assign cmp_band = buf_out[WORD_W-1 -: BAND_W];
  assign cmp_mult = buf_out[OUT_W +: TOP_W];
  assign cmp_data = buf_out[OUT_W-1:0];

  // Register bus slave
  logic aw_hold_ff, nxt_aw_hold, w_hold_ff, nxt_w_hold, bvalid_ff, nxt_bvalid;
  logic rvalid_ff, nxt_rvalid;
  logic [ADDR_W-1:0] awaddr_ff, nxt_awaddr;
  logic [31:0] wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
  logic [3:0] wstrb_ff, nxt_wstrb;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [ADDR_W-1:0] moff;

  assign s_axi_awready = !aw_hold_ff;
  assign s_axi_wready = !w_hold_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign moff = s_axi_araddr - MASK_BASE;

  always_comb
  begin
    nxt_aw_hold = aw_hold_ff;
    nxt_w_hold = w_hold_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bvalid = bvalid_ff && !s_axi_bready;
    nxt_bresp = bresp_ff;
    nxt_en = en_ff;
    nxt_rvalid = rvalid_ff && !s_axi_rready;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (s_axi_awvalid && !aw_hold_ff)
    begin
      nxt_aw_hold = 1'b1;
      nxt_awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_hold_ff)
    begin
      nxt_w_hold = 1'b1;
      nxt_wdata = s_axi_wdata;
      nxt_wstrb = s_axi_wstrb;
    end
    if (aw_hold_ff && w_hold_ff && !bvalid_ff)
    begin
      nxt_aw_hold = 1'b0;
      nxt_w_hold = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = addr_known(awaddr_ff) ? RESP_OKAY : RESP_DECERR;
      if (awaddr_ff == CTRL_ADDR && wstrb_ff[0])
      begin
        nxt_en = wdata_ff[CTRL_EN_BIT];
      end
    end
    if (s_axi_arvalid && !rvalid_ff)
    begin
      nxt_rvalid = 1'b1;
      nxt_rdata = '0;
      nxt_rresp = addr_known(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
      if (s_axi_araddr == CTRL_ADDR)
      begin
        nxt_rdata[CTRL_EN_BIT] = en_ff;
      end
      else if (s_axi_araddr == STATUS_ADDR)
      begin
        nxt_rdata[ST_MANUAL_BIT] = manual_ff;
        nxt_rdata[ST_DRAIN_BIT] = (st_ff == ST_DRAIN);
        nxt_rdata[ST_ACC_LSB +: CNT_W] = acc_cnt_ff;
        nxt_rdata[ST_REJ_LSB +: CNT_W] = rej_cnt_ff;
      end
      else if (addr_known(s_axi_araddr))
      begin
        nxt_rdata[TOP_W-1:0] = masks_ff[moff[5:2]];
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      en_ff <= CTRL_EN_RESET;
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
    end
    else
    begin
      aw_hold_ff <= nxt_aw_hold;
      w_hold_ff <= nxt_w_hold;
      awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      en_ff <= nxt_en;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

  sequence fill_end_s;
    take && wr_idx_ff == LAST_CH;
  endsequence

  sequence drain_start_s;
    st_ff == ST_DRAIN && rd_idx_ff == '0;
  endsequence

  reset_masks_a: assert property (@(posedge aclk) !aresetn |=>
    (masks_ff == MASK_RESET && !manual_ff)) else $error("reset mask values wrong");
  manual_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
    manual_ff |=> manual_ff) else $error("manual mode dropped");
  accept_loads_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_accept |=> manual_ff && masks_ff == $past(cmd_masks)) else $error("masks not loaded");
  reject_keeps_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_reject && !cmd_accept |=> $stable(masks_ff) && $stable(manual_ff))
    else $error("rejected command changed masks");
  fill_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
    fill_end_s |=> drain_start_s) else $error("drain did not follow channel 4095");
  auto_top_a: assert property (@(posedge aclk) disable iff (!aresetn)
    fill_end_s ##1 (!snap_man_ff) |-> top_ff[0] == msb_of(or_ff[0]))
    else $error("auto top bit wrong");
  mult_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    pend_ff && snap_man_ff |-> buf_in[OUT_W +: TOP_W] == '0) else $error("multiplier not zero");
  window_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
    pend_ff && top_ff[rd_band_ff] >= TOP_MIN |->
    buf_in[OUT_W-1] == rd_data_ff[top_ff[rd_band_ff]]) else $error("window misplaced");
  snap_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    st_ff == ST_DRAIN ##1 st_ff == ST_DRAIN |-> $stable(sel_ff) && $stable(top_ff))
    else $error("masks changed mid spectrum");
endmodule

// file: test/smc_tc_source.sv
`timescale 1ns/1ps
module smc_tc_source (
  input wire logic aclk,
  output logic [7:0] tc_data,
  output logic tc_valid,
  output logic tc_last,
  output logic [31:0] spec_data,
  output logic spec_cal,
  output logic spec_valid,
  input wire logic spec_ready
);
  // One counter covers the only id and category pair in use
  logic [10:0] seq_ff = 11'h000;
  initial
  begin
    tc_data = 8'h00;
    tc_valid = 1'b0;
    tc_last = 1'b0;
    spec_data = 32'h0;
    spec_cal = 1'b0;
    spec_valid = 1'b0;
  end
  task automatic send(input logic [7:0] v [14], input logic bad);
    logic [7:0] p [26];
    logic [15:0] ck;
    int i;
    p[0] = 8'h1c;
    p[1] = 8'h7c;
    p[2] = {5'h18, seq_ff[10:8]};
    p[3] = seq_ff[7:0];
    p[4] = 8'h00;
    p[5] = 8'h13;
    p[6] = 8'h11;
    p[7] = 8'hc0;
    p[8] = 8'h12;
    p[9] = 8'h00;
    ck = 16'h0;
    for (i = 0; i < 14; i++)
      p[10+i] = v[i];
    for (i = 0; i < 24; i += 2)
      ck ^= {p[i], p[i+1]};
    // Bad flag spoils the checksum on purpose
    p[24] = ck[15:8] ^ {7'h00, bad};
    p[25] = ck[7:0];
    seq_ff = seq_ff + 11'h001;
    for (i = 0; i < 26; i++)
    begin
      @(posedge aclk);
      tc_valid <= 1'b1;
      tc_data <= p[i];
      tc_last <= (i == 25);
    end
    @(posedge aclk);
    tc_valid <= 1'b0;
    tc_last <= 1'b0;
    tc_data <= ~p[25];
  endtask
  task automatic stream(input logic [31:0] x, input logic cal);
    int n;
    n = 0;
    @(posedge aclk);
    spec_valid <= 1'b1;
    spec_data <= x;
    spec_cal <= cal;
    while (n < 4096)
    begin
      @(posedge aclk);
      if (spec_ready)
        n++;
    end
    spec_valid <= 1'b0;
    spec_data <= ~x;
  endtask
endmodule

// file: test/test_spectrum_mask_cmd_compressor.sv
`timescale 1ns/1ps
module test_spectrum_mask_cmd_compressor;
  import smc_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic cmp_ready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, tc_valid, tc_last, tc_ready;
  logic spec_cal, spec_valid, spec_ready, cmp_valid, mode_manual, man;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, spec_data, rd, cur_x;
  logic [7:0] tc_data;
  logic [7:0] m [14];
  logic [OUT_W-1:0] cmp_data;
  logic [BAND_W-1:0] cmp_band;
  logic [TOP_W-1:0] cmp_mult;
  int fail_count = 0, comparisons = 0, oc = 0, cyc = 0, i, b, k;
  int exp_s [7];
  always #5 aclk = ~aclk;
  smc_compressor smc_compressor_inst (.aclk, .aresetn, .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .tc_data, .tc_valid, .tc_last, .tc_ready, .spec_data,
    .spec_cal, .spec_valid, .spec_ready, .cmp_data, .cmp_band, .cmp_mult,
    .cmp_valid, .cmp_ready, .mode_manual);
  smc_tc_source smc_tc_source_inst (.aclk, .tc_data, .tc_valid, .tc_last,
    .spec_data, .spec_cal, .spec_valid, .spec_ready);
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic run(input logic [31:0] x, input logic cal);
    cur_x = x;
    oc = 0;
    smc_tc_source_inst.stream(x, cal);
    while (oc < 4096)
      @(posedge aclk);
    chk("words", oc, 4096);
  endtask
  // Receiver stalls every other cycle to load the output buffer
  always @(posedge aclk)
  begin
    cyc++;
    cmp_ready <= ~cmp_ready;
    if (cmp_valid && cmp_ready)
    begin
      b = 0;
      for (k = 1; k < 7; k++)
        if (oc >= BAND_START[k])
          b = k;
      chk("cmp_band", cmp_band, b);
      chk("cmp_data", cmp_data, (cur_x >> exp_s[b]) & 32'hfff);
      chk("cmp_mult", cmp_mult, man ? 0 : exp_s[b]);
      oc++;
    end
    if (cyc == 60000)
    begin
      fail_count++;
      give_verdict();
    end
  end
  initial
  begin
    man = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 14; i++)
    begin
      axr(MASK_BASE + 8'(4 * i), rd, r);
      chk("mask_reset", rd, i < 7 ? 0 : 11);
      m[i] = 8'(i < 7 ? 11 + i : 31 - 3 * (i - 7));
    end
    chk("manual_reset", mode_manual, 0);
    chk("tc_ready", tc_ready, 1);
    axr(8'h80, rd, r);
    chk("unmapped_resp", r, RESP_DECERR);
    chk("unmapped_data", rd, 0);
    axw(CTRL_ADDR, 32'h0, r);
    chk("spec_ready_off", spec_ready, 0);
    // Byte strobe low must leave the enable alone
    wstrb <= 4'h0;
    axw(CTRL_ADDR, 32'h1, r);
    chk("strobe_masked", spec_ready, 0);
    wstrb <= 4'hf;
    axw(CTRL_ADDR, 32'h1, r);
    chk("ctrl_resp", r, RESP_OKAY);
    chk("spec_ready_on", spec_ready, 1);
    axr(CTRL_ADDR, rd, r);
    chk("ctrl_read", rd, 1);
    $display("test registers done");
    for (i = 0; i < 7; i++)
      exp_s[i] = 12;
    run(32'h00abc123, 1'b0);
    $display("test auto done");
    m[3] = 8'h0a;
    smc_tc_source_inst.send(m, 1'b0);
    m[3] = 8'h20;
    smc_tc_source_inst.send(m, 1'b0);
    m[3] = 8'h0e;
    smc_tc_source_inst.send(m, 1'b1);
    repeat (3) @(posedge aclk);
    axr(STATUS_ADDR, rd, r);
    chk("rejects", rd[23:16], 3);
    chk("manual_rej", mode_manual, 0);
    axr(MASK_BASE + 8'h0c, rd, r);
    chk("mask_rej", rd, 0);
    $display("test reject done");
    smc_tc_source_inst.send(m, 1'b0);
    repeat (3) @(posedge aclk);
    chk("manual_set", mode_manual, 1);
    axr(STATUS_ADDR, rd, r);
    chk("accepts", rd[15:8], 1);
    for (i = 0; i < 14; i++)
    begin
      axr(MASK_BASE + 8'(4 * i), rd, r);
      chk("mask", rd, m[i]);
    end
    man = 1'b1;
    for (i = 0; i < 7; i++)
      exp_s[i] = m[7+i] - 11;
    run(32'hfedcba98, 1'b0);
    for (i = 0; i < 7; i++)
      exp_s[i] = m[i] - 11;
    for (i = 0; i < 7; i++)
      m[i] = 8'h14;
    // Command lands mid-fill; this spectrum keeps the old masks
    fork
      run(32'h7f3c5a96, 1'b1);
      begin
        repeat (200) @(posedge aclk);
        smc_tc_source_inst.send(m, 1'b0);
      end
    join
    axr(MASK_BASE, rd, r);
    chk("mask_late", rd, 8'h14);
    chk("manual_kept", mode_manual, 1);
    $display("test manual done");
    give_verdict();
  end
endmodule
